// File: hdl/aidi_core.sv
// Purpose: Limit interrupts, diagnostic incoming/going lifecycle and record readout for a 4-channel analog input.
// Assumes: All fault and measurement inputs come from logic on the same clock.
// Notes:   Records are read one byte at a time through a request/answer port.

`timescale 1ns/10ps

module aidi_core
#(
   parameter int unsigned NUM_CH = 4
)
(
   input  wire logic                   i_clock,
   input  wire logic                   i_nrst,
   input  wire logic                   i_hw_irq_en,
   input  wire logic                   i_diag_irq_en,
   input  wire logic                   i_meas_valid,
   input  wire logic [1:0]             i_meas_chan,
   input  wire logic [15:0]            i_meas_value,
   input  wire logic [NUM_CH-1:0][15:0] i_upper_limit_value,
   input  wire logic [NUM_CH-1:0][15:0] i_lower_limit_value,
   input  wire logic                   i_hw_ack,
   input  wire logic [NUM_CH-1:0]      i_param_err,
   input  wire logic [NUM_CH-1:0]      i_wire_break,
   input  wire logic [NUM_CH-1:0]      i_range_under,
   input  wire logic [NUM_CH-1:0]      i_range_over,
   input  wire logic                   i_module_fail,
   input  wire logic                   i_internal_err,
   input  wire logic                   i_external_err,
   input  wire logic                   i_aux_missing,
   input  wire logic                   i_module_param_err,
   input  wire logic                   i_buf_overflow,
   input  wire logic                   i_comm_err,
   input  wire logic                   i_rd_req,
   input  wire logic [1:0]             i_rd_sel,
   input  wire logic [4:0]             i_rd_index,
   output logic                        o_hw_irq,
   output logic                        o_hw_pending,
   output logic                        o_diag_incoming,
   output logic                        o_diag_going,
   output logic                        o_module_fault_indicator,
   output logic                        o_rd_valid,
   output logic                        o_rd_error,
   output logic [7:0]                  o_rd_data,
   output logic [31:0]                 o_ticker
);

   // ----------------------------------------------------------------
   // Microsecond ticker
   // ----------------------------------------------------------------
   localparam logic [4:0] DIV_LAST = 5'(aidi_pkg::CYCLES_PER_US - 1);

   logic [4:0]  div_q;
   logic        us_tick;
   logic [31:0] ticker_q;

   assign us_tick = (div_q == DIV_LAST);

   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
         div_q <= 5'h00;
      else if (us_tick)
         div_q <= 5'h00;
      else
         div_q <= div_q + 5'h01;
   end

   // Natural 32-bit overflow gives the wrap to zero.
   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
         ticker_q <= 32'h0000_0000;
      else if (us_tick)
         ticker_q <= ticker_q + 32'h0000_0001;
   end

   assign o_ticker = ticker_q;

   // ----------------------------------------------------------------
   // Limit checking and hardware interrupt record
   // ----------------------------------------------------------------
   function automatic logic beyond_upper(input logic [15:0] value, input logic [15:0] limit);
      beyond_upper = (limit != aidi_pkg::LIMIT_UPPER_OFF) && ($signed(value) > $signed(limit));
   endfunction

   function automatic logic beyond_lower(input logic [15:0] value, input logic [15:0] limit);
      beyond_lower = (limit != aidi_pkg::LIMIT_LOWER_OFF) && ($signed(value) < $signed(limit));
   endfunction

   logic       hit_over;
   logic       hit_under;
   logic       limit_event;
   logic [7:0] chan_bit;
   logic [7:0] limit_over_flags_q;
   logic [7:0] limit_under_flags_q;
   logic [15:0] interrupt_timestamp_q;
   logic       pending_q;
   logic [NUM_CH-1:0] hw_lost_q;

   assign hit_over    = beyond_upper(i_meas_value, i_upper_limit_value[i_meas_chan]);
   assign hit_under   = beyond_lower(i_meas_value, i_lower_limit_value[i_meas_chan]);
   assign limit_event = i_meas_valid && i_hw_irq_en && (hit_over || hit_under);
   assign chan_bit    = 8'h01 << i_meas_chan;

   // A new event while the previous record is still unacknowledged cannot be delivered.
   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         limit_over_flags_q    <= aidi_pkg::RST_LIMIT_FLAGS;
         limit_under_flags_q   <= aidi_pkg::RST_LIMIT_FLAGS;
         interrupt_timestamp_q <= aidi_pkg::RST_TIMESTAMP;
      end
      else if (limit_event && !pending_q)
      begin
         limit_over_flags_q    <= hit_over ? chan_bit : 8'h00;
         limit_under_flags_q   <= hit_under ? chan_bit : 8'h00;
         interrupt_timestamp_q <= ticker_q[15:0];
      end
   end

   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
         pending_q <= 1'b0;
      else if (limit_event && !pending_q)
         pending_q <= 1'b1;
      else if (i_hw_ack)
         pending_q <= 1'b0;
   end

   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
         o_hw_irq <= 1'b0;
      else
         o_hw_irq <= limit_event && !pending_q;
   end

   assign o_hw_pending = pending_q;

   // Set wins over the acknowledge that clears the lost flags.
   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
         hw_lost_q <= '0;
      else if (limit_event && pending_q)
         hw_lost_q <= hw_lost_q | chan_bit[NUM_CH-1:0];
      else if (i_hw_ack)
         hw_lost_q <= '0;
   end

   // ----------------------------------------------------------------
   // Live diagnostic bytes
   // ----------------------------------------------------------------
   logic [NUM_CH-1:0][7:0] chan_live;
   logic [7:0] chan_summary_live;
   logic [7:0] summary_live;
   logic [7:0] fourth_live;
   logic       cause_live;

   for (genvar c = 0; c < NUM_CH; c++)
   begin : g_chan
      always_comb
      begin
         chan_live[c]                         = 8'h00;
         chan_live[c][aidi_pkg::CH_PARAM]      = i_param_err[c];
         chan_live[c][aidi_pkg::CH_WIRE_BREAK] = i_wire_break[c];
         chan_live[c][aidi_pkg::CH_HW_LOST]    = hw_lost_q[c];
         chan_live[c][aidi_pkg::CH_UNDER]      = i_range_under[c];
         chan_live[c][aidi_pkg::CH_OVER]       = i_range_over[c];
      end
   end

   // One process owns the whole summary byte so that no bit has two writers.
   always_comb
   begin
      chan_summary_live = 8'h00;
      for (int k = 0; k < NUM_CH; k++)
         chan_summary_live[k] = |chan_live[k];
   end

   always_comb
   begin
      summary_live                            = 8'h00;
      summary_live[aidi_pkg::SUM_MODULE_FAIL] = i_module_fail;
      summary_live[aidi_pkg::SUM_INTERNAL]    = i_internal_err;
      summary_live[aidi_pkg::SUM_EXTERNAL]    = i_external_err;
      summary_live[aidi_pkg::SUM_CHANNEL]     = |chan_summary_live;
      summary_live[aidi_pkg::SUM_AUX_MISSING] = i_aux_missing;
      summary_live[aidi_pkg::SUM_PARAM]       = i_module_param_err;
      fourth_live                             = 8'h00;
      fourth_live[aidi_pkg::D4_BUF_OVF]       = i_buf_overflow;
      fourth_live[aidi_pkg::D4_COMM_ERR]      = i_comm_err;
      fourth_live[aidi_pkg::D4_HW_LOST]       = |hw_lost_q;
   end

   assign cause_live = (summary_live != 8'h00) || (fourth_live != 8'h00);

   // ----------------------------------------------------------------
   // Diagnostic lifecycle and frozen record
   // ----------------------------------------------------------------
   aidi_pkg::aidi_diag_state_t state_q;
   logic [7:0]             diag_summary_first_q;
   logic [7:0]             diag_summary_fourth_q;
   logic [7:0]             channel_fault_summary_q;
   logic [NUM_CH-1:0][7:0] chan_fault_byte_q;
   logic [31:0]            diag_timestamp_q;
   logic                   go_in;
   logic                   go_out;

   assign go_in  = (state_q == aidi_pkg::DIAG_IDLE) && cause_live && i_diag_irq_en;
   assign go_out = (state_q == aidi_pkg::DIAG_ACTIVE) && !cause_live;

   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
         state_q <= aidi_pkg::DIAG_IDLE;
      else
      begin
         case (state_q)
            aidi_pkg::DIAG_IDLE:
               if (go_in)
                  state_q <= aidi_pkg::DIAG_ACTIVE;
            aidi_pkg::DIAG_ACTIVE:
               if (go_out)
                  state_q <= aidi_pkg::DIAG_IDLE;
            default:
               state_q <= aidi_pkg::DIAG_IDLE;
         endcase
      end
   end

   // The record is captured once at incoming; later changes are not stored, not even at going.
   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         diag_summary_first_q    <= 8'h00;
         diag_summary_fourth_q   <= 8'h00;
         channel_fault_summary_q <= 8'h00;
         chan_fault_byte_q       <= '0;
         diag_timestamp_q        <= 32'h0000_0000;
      end
      else if (go_in)
      begin
         diag_summary_first_q    <= summary_live;
         diag_summary_fourth_q   <= fourth_live;
         channel_fault_summary_q <= chan_summary_live;
         chan_fault_byte_q       <= chan_live;
         diag_timestamp_q        <= ticker_q;
      end
   end

   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_diag_incoming <= 1'b0;
         o_diag_going    <= 1'b0;
      end
      else
      begin
         o_diag_incoming <= go_in;
         o_diag_going    <= go_out;
      end
   end

   assign o_module_fault_indicator = (state_q == aidi_pkg::DIAG_ACTIVE);

   // ----------------------------------------------------------------
   // Record readout
   // ----------------------------------------------------------------
   logic [7:0] diag_byte;
   logic [7:0] hw_byte;
   logic [4:0] rd_len;
   logic [4:0] rel_idx;

   assign rel_idx = i_rd_index - aidi_pkg::IDX_TS_FIRST;

   always_comb
   begin
      case (i_rd_index)
         5'h00:   diag_byte = diag_summary_first_q;
         5'h01:   diag_byte = aidi_pkg::MODULE_CLASS;
         5'h02:   diag_byte = aidi_pkg::RESERVED_BYTE;
         5'h03:   diag_byte = diag_summary_fourth_q;
         5'h04:   diag_byte = aidi_pkg::CHANNEL_KIND;
         5'h05:   diag_byte = aidi_pkg::DIAG_BITS_PER_CH;
         5'h06:   diag_byte = aidi_pkg::CHANNEL_COUNT;
         5'h07:   diag_byte = channel_fault_summary_q;
         5'h08, 5'h09, 5'h0a, 5'h0b:
                  diag_byte = chan_fault_byte_q[i_rd_index[1:0]];
         5'h10, 5'h11, 5'h12, 5'h13:
                  diag_byte = diag_timestamp_q[rel_idx[1:0]*8 +: 8];
         default: diag_byte = aidi_pkg::RESERVED_BYTE;
      endcase
      case (i_rd_index[1:0])
         2'h0:    hw_byte = limit_over_flags_q;
         2'h1:    hw_byte = limit_under_flags_q;
         2'h2:    hw_byte = interrupt_timestamp_q[15:8];
         default: hw_byte = interrupt_timestamp_q[7:0];
      endcase
      case (i_rd_sel)
         aidi_pkg::SEL_HW_RECORD:  rd_len = aidi_pkg::HW_RECORD_LEN;
         aidi_pkg::SEL_DIAG_SHORT: rd_len = aidi_pkg::DIAG_SHORT_LEN;
         aidi_pkg::SEL_DIAG_FULL:  rd_len = aidi_pkg::DIAG_FULL_LEN;
         default:                  rd_len = 5'h00;
      endcase
   end

   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_rd_valid <= 1'b0;
         o_rd_error <= 1'b0;
         o_rd_data  <= 8'h00;
      end
      else
      begin
         o_rd_valid <= i_rd_req;
         o_rd_error <= i_rd_req && (i_rd_index >= rd_len);
         if (i_rd_req)
         begin
            if (i_rd_index >= rd_len)
               o_rd_data <= 8'h00;
            else if (i_rd_sel == aidi_pkg::SEL_HW_RECORD)
               o_rd_data <= hw_byte;
            else
               o_rd_data <= diag_byte;
         end
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_nrst);

   chk_hw_irq_gate: assert property (o_hw_irq |-> $past(i_hw_irq_en) && $past(i_meas_valid))
      else $error("hardware interrupt without enable or measurement");
   chk_ticker_step: assert property (us_tick |=> ticker_q == $past(ticker_q) + 32'h0000_0001)
      else $error("ticker did not advance on microsecond tick");
   chk_ticker_rate: assert property (us_tick |=> !us_tick [*8] ##1 !us_tick [*8] ##1 !us_tick [*3]
                                     ##1 us_tick)
      else $error("microsecond tick spacing wrong");
   chk_ts_capture: assert property (o_hw_irq |-> interrupt_timestamp_q == $past(ticker_q[15:0]))
      else $error("interrupt timestamp not the ticker low half");
   chk_flag_reserved: assert property (limit_over_flags_q[7:4] == 4'h0 && limit_under_flags_q[7:4] == 4'h0)
      else $error("reserved limit flag bits set");
   chk_diag_gate: assert property (o_diag_incoming |-> $past(i_diag_irq_en))
      else $error("diagnostic incoming without enable");
   chk_going_auto: assert property (state_q == aidi_pkg::DIAG_ACTIVE && !cause_live |=> o_diag_going && !o_module_fault_indicator)
      else $error("going not signalled when cause vanished");
   chk_record_frozen: assert property (state_q == aidi_pkg::DIAG_ACTIVE && $past(o_module_fault_indicator)
                                       |-> $stable(diag_summary_first_q) && $stable(chan_fault_byte_q))
      else $error("diagnostic record changed while active");
   chk_lost_report: assert property (limit_event && pending_q |=> hw_lost_q != '0 ##0 fourth_live[aidi_pkg::D4_HW_LOST])
      else $error("lost hardware interrupt not reported");
   chk_chan_summary: assert property (o_diag_incoming |-> diag_summary_first_q[aidi_pkg::SUM_CHANNEL]
                                      == (channel_fault_summary_q != 8'h00))
      else $error("channel summary bit disagrees with channel bytes");
   chk_short_len: assert property (i_rd_req && i_rd_sel == aidi_pkg::SEL_DIAG_SHORT && i_rd_index == 5'h04
                                   |=> o_rd_valid && o_rd_error)
      else $error("short record not limited to four bytes");

   cov_hw_irq:    cover property (o_hw_irq);
   cov_hw_lost:   cover property (limit_event && pending_q);
   cov_diag_life: cover property (o_diag_incoming ##[1:50] o_diag_going);
   cov_full_read: cover property (i_rd_req && i_rd_sel == aidi_pkg::SEL_DIAG_FULL && i_rd_index == 5'h13);

endmodule

// File: hdl/aidi_pkg.sv
// Purpose: Constants, record layout and state type for the analog input diagnostic and interrupt block.
// Assumes: 20 MHz system clock; four analog channels with 16-bit signed measured values.
// Notes:   Record byte indices are positions within the record read by the host.
//
// What this block does
// - Limit events raise hardware interrupts only while the hardware interrupt function is enabled.
// - Upper-limit flag byte holds channels 0-3 in bits 0-3, upper nibble reserved.
// - Lower-limit flag byte holds channels 0-3 in bits 0-3, bits 7-4 reserved.
// - Hardware interrupt record holds ticker low 16 bits captured when raised.
// - Keep a 32-bit microsecond ticker from zero, incrementing each microsecond, wrapping.
// - Upper flags, lower flags and timestamp of the interrupt record reset to zero.
// - Diagnostic interrupts are raised only while the diagnostic function is enabled.
// - On a new diagnostic cause signal incoming and offer the diagnostic record.
// - When the cause vanishes signal going automatically, without host action.
// - Events between incoming and going are discarded, not stored.
// - Module fault indicator lit from incoming until going.
// - Host may read the first four record bytes by a separate short access.
// - First byte: bits 0,1,2,3,4,7 report module, internal, external, channel, supply, parameter faults.
// - Fourth byte: bit 3 buffer overflow, bit 4 communication error, bit 6 lost hardware interrupt, rest reserved.
// - A lost hardware interrupt sets fourth byte bit 6 and raises a diagnostic interrupt.
// - Module byte reports class 0101b in bits 3-0 and bit 4 channel information.
// - Channel type byte reports 71h in bits 6-0.
// - Record reports 08h diagnostic bits per channel.
// - Record reports a channel count of 04h.
// - Limit 7FFFh upper or 8000h lower disables it; crossing an enabled limit interrupts.
// - Channel byte: bit 0 parameter, 4 wire break, 5 lost interrupt, 6 underflow, 7 overflow.

package aidi_pkg;

   localparam int unsigned CLOCK_HZ        = 20_000_000;
   localparam int unsigned TICK_US         = 1;
   localparam int unsigned CYCLES_PER_US   = CLOCK_HZ / 1_000_000 * TICK_US;

   localparam logic [15:0] LIMIT_UPPER_OFF = 16'h7fff;
   localparam logic [15:0] LIMIT_LOWER_OFF = 16'h8000;

   localparam logic [7:0]  RST_LIMIT_FLAGS = 8'h00;
   localparam logic [15:0] RST_TIMESTAMP   = 16'h0000;
   localparam logic [7:0]  MODULE_CLASS    = 8'h15;
   localparam logic [7:0]  CHANNEL_KIND    = 8'h71;
   localparam logic [7:0]  DIAG_BITS_PER_CH = 8'h08;
   localparam logic [7:0]  CHANNEL_COUNT   = 8'h04;
   localparam logic [7:0]  RESERVED_BYTE   = 8'h00;

   // Summary byte (first record byte) bit positions.
   localparam int unsigned SUM_MODULE_FAIL = 0;
   localparam int unsigned SUM_INTERNAL    = 1;
   localparam int unsigned SUM_EXTERNAL    = 2;
   localparam int unsigned SUM_CHANNEL     = 3;
   localparam int unsigned SUM_AUX_MISSING = 4;
   localparam int unsigned SUM_PARAM       = 7;
   // Fourth record byte bit positions.
   localparam int unsigned D4_BUF_OVF      = 3;
   localparam int unsigned D4_COMM_ERR     = 4;
   localparam int unsigned D4_HW_LOST      = 6;
   // Channel fault byte bit positions.
   localparam int unsigned CH_PARAM        = 0;
   localparam int unsigned CH_WIRE_BREAK   = 4;
   localparam int unsigned CH_HW_LOST      = 5;
   localparam int unsigned CH_UNDER        = 6;
   localparam int unsigned CH_OVER         = 7;

   // Record selectors and byte indices.
   localparam logic [1:0]  SEL_HW_RECORD   = 2'h0;
   localparam logic [1:0]  SEL_DIAG_SHORT  = 2'h1;
   localparam logic [1:0]  SEL_DIAG_FULL   = 2'h2;
   localparam logic [4:0]  HW_RECORD_LEN   = 5'h04;
   localparam logic [4:0]  DIAG_SHORT_LEN  = 5'h04;
   localparam logic [4:0]  DIAG_FULL_LEN   = 5'h14;
   localparam logic [4:0]  IDX_CHAN_FIRST  = 5'h08;
   localparam logic [4:0]  IDX_RSVD_FIRST  = 5'h0c;
   localparam logic [4:0]  IDX_TS_FIRST    = 5'h10;

   typedef enum logic [0:0]
   {
      DIAG_IDLE   = 1'b0,
      DIAG_ACTIVE = 1'b1
   } aidi_diag_state_t;

endpackage

// File: tb/aidi_host_model.sv
// Purpose: Host-side partner that reads record bytes and takes hardware interrupt records.
// Assumes: Everything it drives changes at the falling clock edge.
// Notes:   Acknowledge can be held off or delayed so that lost interrupts can be provoked.
`timescale 1ns/10ps
module aidi_host_model
(
   input  wire logic       i_clock,
   input  wire logic       i_hw_pending,
   input  wire logic       i_ack_en,
   input  wire logic [3:0] i_ack_wait,
   input  wire logic       i_rd_valid,
   input  wire logic       i_rd_error,
   input  wire logic [7:0] i_rd_data,
   output logic            o_hw_ack,
   output logic            o_rd_req,
   output logic [1:0]      o_rd_sel,
   output logic [4:0]      o_rd_index
);
   logic [3:0] wait_q = 4'h0;
   initial
   begin
      o_hw_ack   = 1'b0;
      o_rd_req   = 1'b0;
      o_rd_sel   = 2'h0;
      o_rd_index = 5'h00;
   end
   // A slow host lets the pending record sit for i_ack_wait cycles first.
   always @(negedge i_clock)
   begin
      o_hw_ack <= 1'b0;
      wait_q   <= 4'h0;
      if (i_hw_pending && i_ack_en && !o_hw_ack)
      begin
         wait_q   <= wait_q + 4'h1;
         o_hw_ack <= (wait_q == i_ack_wait);
      end
   end
   // Selector and index are inverted after release so stale values never look valid.
   task automatic read_byte(input logic [1:0] sel, input logic [4:0] idx, output logic [7:0] data,
                            output logic err);
      @(negedge i_clock);
      o_rd_req   = 1'b1;
      o_rd_sel   = sel;
      o_rd_index = idx;
      @(negedge i_clock);
      data       = i_rd_data;
      err        = i_rd_valid ? i_rd_error : 1'bx;
      o_rd_req   = 1'b0;
      o_rd_sel   = ~sel;
      o_rd_index = ~idx;
   endtask
endmodule

// File: tb/tb_analog_input_diag_interrupt.sv
// Purpose: Self-checking bench for the analog input diagnostic and interrupt block.
// Assumes: Inputs change at the falling clock edge; the host model reads and acknowledges.
// Notes:   Expected record bytes are built from the documented layout, never from the design.
`timescale 1ns/10ps
module tb_analog_input_diag_interrupt;
   logic             clk, nrst, hw_en, diag_en, mv, ack_en;
   logic [1:0]       mch;
   logic [15:0]      mval;
   logic [3:0][15:0] up_lim, lo_lim;
   logic [3:0]       perr, wbrk, r_under, r_over, ack_wait;
   logic [6:0]       mod_f;
   wire              ack, req, irq, pend, d_in, d_go, mfi, rv, re;
   wire [1:0]        sel;
   wire [4:0]        idx;
   wire [7:0]        rdat;
   wire [31:0]       ticker;
   int               errors = 0, compares = 0, n_irq = 0, n_in = 0, n_go = 0, cyc = 0;
   logic [7:0]       rec_exp [20] = '{1:8'h15, 4:8'h71, 5:8'h08, 6:8'h04, default:8'h00};
   logic [15:0]      mod_exp [7] = '{16'h0100, 16'h0200, 16'h0400, 16'h1000, 16'h8000, 16'h0008, 16'h0010};
   logic [7:0]       ch_exp [4] = '{8'h80, 8'h40, 8'h10, 8'h01};

   aidi_core dut (.i_clock(clk), .i_nrst(nrst), .i_hw_irq_en(hw_en), .i_diag_irq_en(diag_en),
      .i_meas_valid(mv), .i_meas_chan(mch), .i_meas_value(mval), .i_upper_limit_value(up_lim),
      .i_lower_limit_value(lo_lim), .i_hw_ack(ack), .i_param_err(perr), .i_wire_break(wbrk),
      .i_range_under(r_under), .i_range_over(r_over), .i_module_fail(mod_f[0]),
      .i_internal_err(mod_f[1]), .i_external_err(mod_f[2]), .i_aux_missing(mod_f[3]),
      .i_module_param_err(mod_f[4]), .i_buf_overflow(mod_f[5]), .i_comm_err(mod_f[6]),
      .i_rd_req(req), .i_rd_sel(sel), .i_rd_index(idx), .o_hw_irq(irq), .o_hw_pending(pend),
      .o_diag_incoming(d_in), .o_diag_going(d_go), .o_module_fault_indicator(mfi),
      .o_rd_valid(rv), .o_rd_error(re), .o_rd_data(rdat), .o_ticker(ticker));
   aidi_host_model host (.i_clock(clk), .i_hw_pending(pend), .i_ack_en(ack_en), .i_ack_wait(ack_wait),
      .i_rd_valid(rv), .i_rd_error(re), .i_rd_data(rdat), .o_hw_ack(ack), .o_rd_req(req),
      .o_rd_sel(sel), .o_rd_index(idx));

   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Pulses are tallied here so that no scenario can miss a one-cycle output.
   always @(posedge clk)
   begin
      n_irq += irq;
      n_in  += d_in;
      n_go  += d_go;
      cyc++;
      if (cyc == 8000)
      begin
         errors++;
         wrap_up();
      end
   end

   //----------------------------------------------------------------------------
   // Shared tasks
   //----------------------------------------------------------------------------
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask
   task automatic rd(input logic [1:0] s, input logic [4:0] i, input logic [7:0] exp, input logic err);
      logic [7:0] d;
      logic       e;
      host.read_byte(s, i, d, e);
      check($sformatf("read error %0d/%0d", s, i), {31'h0, e}, {31'h0, err});
      check($sformatf("read byte %0d/%0d", s, i), {24'h0, d}, {24'h0, exp});
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic ev(input logic [1:0] c, input logic [15:0] v);
      @(negedge clk);
      mv   = 1'b1;
      mch  = c;
      mval = v;
      @(negedge clk);
      mv   = 1'b0;
   endtask
   task automatic hw_ack(input logic [3:0] w);
      ack_wait = w;
      ack_en   = 1'b1;
      idle(8);
      ack_en   = 1'b0;
   endtask

   //----------------------------------------------------------------------------
   // Scenarios
   //----------------------------------------------------------------------------
   task automatic t_reset();
      for (int i = 0; i < 20; i++) rd(2'h2, i[4:0], rec_exp[i], 1'b0);
      for (int i = 0; i < 4; i++) rd(2'h0, i[4:0], 8'h00, 1'b0);
      for (int i = 0; i < 4; i++) rd(2'h1, i[4:0], rec_exp[i], 1'b0);
      rd(2'h1, 5'h04, 8'h00, 1'b1);
      rd(2'h3, 5'h00, 8'h00, 1'b1);
   endtask
   task automatic t_ticker();
      logic [31:0] t0;
      t0 = ticker;
      idle(200);
      check("ticker advance", ticker - t0, 32'd10);
   endtask
   task automatic t_limit();
      logic [31:0] t0;
      logic [15:0] ts;
      logic        e;
      int          n;
      up_lim[1] = 16'd100;
      lo_lim[3] = 16'hff9c;
      n = n_irq;
      hw_en = 1'b1;
      ev(2'd1, 16'd100);
      ev(2'd3, 16'hff9c);
      hw_en = 1'b0;
      ev(2'd1, 16'd200);
      idle(2);
      check("irq count quiet", n_irq, n);
      hw_en = 1'b1;
      t0 = ticker;
      ev(2'd1, 16'd101);
      idle(1);
      check("irq count over", n_irq, n + 1);
      check("pending set", {31'h0, pend}, 32'h1);
      rd(2'h0, 5'h00, 8'h02, 1'b0);
      rd(2'h0, 5'h01, 8'h00, 1'b0);
      host.read_byte(2'h0, 5'h02, ts[15:8], e);
      host.read_byte(2'h0, 5'h03, ts[7:0], e);
      check("timestamp", {31'h0, ts == t0[15:0] || ts == t0[15:0] + 16'h1}, 32'h1);
      hw_ack(4'h0);
      check("pending cleared", {31'h0, pend}, 32'h0);
      ev(2'd3, 16'hff9b);
      idle(1);
      check("irq count under", n_irq, n + 2);
      rd(2'h0, 5'h01, 8'h08, 1'b0);
      hw_ack(4'h5);
   endtask
   task automatic t_lost();
      int n, g;
      n = n_in;
      g = n_go;
      up_lim[0] = 16'd100;
      ev(2'd0, 16'd200);
      ev(2'd1, 16'd101);
      idle(3);
      check("incoming on lost", n_in, n + 1);
      check("indicator on", {31'h0, mfi}, 32'h1);
      rd(2'h2, 5'h03, 8'h40, 1'b0);
      rd(2'h2, 5'h09, 8'h20, 1'b0);
      rd(2'h2, 5'h07, 8'h02, 1'b0);
      rd(2'h2, 5'h00, 8'h08, 1'b0);
      hw_ack(4'h3);
      check("going after ack", n_go, g + 1);
      check("indicator off", {31'h0, mfi}, 32'h0);
   endtask
   task automatic t_diag();
      int n, g;
      n = n_in;
      g = n_go;
      {r_over[0], r_under[1], wbrk[2], perr[3]} = 4'hf;
      idle(3);
      check("incoming", n_in, n + 1);
      perr[0] = 1'b1;
      for (int i = 0; i < 4; i++) rd(2'h2, 5'h08 + i[4:0], ch_exp[i], 1'b0);
      rd(2'h2, 5'h07, 8'h0f, 1'b0);
      rd(2'h1, 5'h00, 8'h08, 1'b0);
      {r_over, r_under, wbrk, perr} = 16'h0;
      idle(3);
      check("going", n_go, g + 1);
      check("indicator after going", {31'h0, mfi}, 32'h0);
      diag_en = 1'b0;
      wbrk[0] = 1'b1;
      idle(4);
      check("incoming disabled", n_in, n + 1);
      wbrk[0] = 1'b0;
      idle(2);
      diag_en = 1'b1;
      for (int i = 0; i < 7; i++)
      begin
         mod_f = 7'h1 << i;
         idle(3);
         rd(2'h2, 5'h00, mod_exp[i][15:8], 1'b0);
         rd(2'h2, 5'h03, mod_exp[i][7:0], 1'b0);
         mod_f = 7'h0;
         idle(3);
      end
      check("fault cycles", n_go, g + 8);
   endtask
   task automatic t_rerst();
      nrst = 1'b0;
      idle(2);
      nrst = 1'b1;
      idle(1);
      check("ticker after reset", ticker, 32'h0);
      rd(2'h0, 5'h00, 8'h00, 1'b0);
      rd(2'h0, 5'h02, 8'h00, 1'b0);
   endtask

   task automatic wrap_up();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial
   begin
      {nrst, hw_en, mv, ack_en, mch, mval, mod_f} = '0;
      {perr, wbrk, r_under, r_over, ack_wait} = '0;
      diag_en = 1'b1;
      up_lim  = {4{16'h7fff}};
      lo_lim  = {4{16'h8000}};
      idle(6);
      nrst = 1'b1;
      t_reset();
      t_ticker();
      t_limit();
      t_lost();
      t_diag();
      t_rerst();
      wrap_up();
   end
endmodule
